// file: core/phsc_pkg.sv
// shared constants for the strap loader and indicator block
package phsc_pkg;
	// ----------------------------------------
	// register indices, byte address is index times four
	// ----------------------------------------
	localparam logic [5:0] IDX_CTRL  = 6'h00;
	localparam logic [5:0] IDX_ADV   = 6'h04;
	localparam logic [5:0] IDX_CFG   = 6'h17;
	localparam logic [5:0] IDX_BYP   = 6'h18;
	localparam logic [5:0] IDX_STAT10 = 6'h1B;
	localparam logic [5:0] IDX_MODE  = 6'h20;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL_AN_EN   = 8;
	localparam int CTRL_ISOLATE = 10;
	localparam int CTRL_PDOWN   = 11;
	localparam int ADV_10H      = 5;
	localparam int ADV_10F      = 6;
	localparam int ADV_100H     = 7;
	localparam int ADV_100F     = 8;
	localparam int CFG_POL_SEL  = 1;
	localparam int CFG_DISC_SEL = 2;
	localparam int CFG_LOCK_SEL = 11;
	localparam int BYP_ALIGN    = 12;
	localparam int BYP_SCR      = 13;
	localparam int BYP_CODER    = 14;
	localparam int STAT10_SER   = 9;
	// ----------------------------------------
	// write masks and reset values
	// ----------------------------------------
	localparam logic [15:0] CTRL_WMASK  = 16'h0D00;
	localparam logic [15:0] ADV_WMASK   = 16'h05E0;
	localparam logic [15:0] CFG_WMASK   = 16'h0806;
	localparam logic [15:0] BYP_WMASK   = 16'h7000;
	localparam logic [15:0] STAT10_WMASK = 16'h0200;
	localparam logic [15:0] CFG_RESET   = 16'h0000;
	// ----------------------------------------
	// three-level strap codes
	// ----------------------------------------
	localparam logic [1:0] TL_LOW  = 2'h0;
	localparam logic [1:0] TL_HIGH = 2'h1;
	localparam logic [1:0] TL_MID  = 2'h2;
	// ----------------------------------------
	// indicator slots
	// ----------------------------------------
	localparam int IND_TX   = 0;
	localparam int IND_RX   = 1;
	localparam int IND_LINK = 2;
	localparam int IND_DPX  = 3;
	localparam int IND_COL  = 4;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ       = 10000000;
	localparam int STRETCH_MS   = 40;
	localparam int STRETCH_CYC  = CLK_HZ / 1000 * STRETCH_MS;
	localparam int STRETCH_W    = 20;
endpackage : phsc_pkg

// file: core/phsc_strap_loader.sv
// strap capture, mode registers, control pins and indicators
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/10ps
// Notes on behaviour
// R1: serial strap high at 10 Mb/s moves data bitwise; ignored at 100 Mb/s.
// R2: serial strap latched into 1Bh bit 9 at reset; writable by software.
// R3: negotiation straps are three-level; floating reads as mid.
// R4: exactly one mid strap forces a fixed speed and duplex.
// R5: both mid advertise all; both defined advertise one chosen mode.
// R6: software sets negotiation at 00h bit 8, abilities at 04h bits 5-8,10.
// R7: coder bypass strap skips 4B5B coders, raw five-bit groups pass.
// R8: coder bypass strap latched into 18h bit 14; writable by software.
// R9: alignment bypass skips coders, scrambler and NRZI; unaligned words.
// R10: alignment bypass strap latched into 18h bit 12; writable by software.
// R11: scrambler bypass strap bypasses scrambler pair and selects fiber mode.
// R12: scrambler bypass strap latched into 18h bit 13; writable by software.
// R13: isolate strap high leaves reset with MII isolated except management.
// R14: isolate strap latched into 00h bit 10; software can isolate too.
// R15: tx indicator stretched activity, or disconnect when 17h bit 2 set.
// R16: rx indicator stretched activity; link indicator low on valid link.
// R17: duplex indicator shows full duplex at 100, polarity or duplex at 10.
// R18: collision indicator stretched collision, or descrambler lock if 17h bit 11.
// R19: loopback pin loops PMD at 100 Mb/s, coder loopback at 10 Mb/s.
// R20: low power start strap holds low power until reset or mdc toggles.
// R21: power down pin holds lowest power while high.
// R22: 00h bit 11 enters software power down.
// R23: reset is active high, reinitialises and captures all straps.
// R24: stretch interval fixed and parameterised, retriggered on each event.
module phsc_strap_loader #(
	parameter int STRETCH_CYCLES = phsc_pkg::STRETCH_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        serial_mode_strap,
	input  wire logic [1:0]  negotiation_strap_pair_1,
	input  wire logic [1:0]  negotiation_strap_pair_0,
	input  wire logic        coder_bypass_strap,
	input  wire logic        alignment_bypass_strap,
	input  wire logic        scrambler_bypass_strap,
	input  wire logic        isolate_default_strap,
	input  wire logic        low_power_start_strap_n,
	input  wire logic        loopback_pin,
	input  wire logic        power_down_pin,
	input  wire logic        mdc,
	input  wire logic        an_speed100,
	input  wire logic        an_full,
	input  wire logic        tx_active,
	input  wire logic        rx_active,
	input  wire logic        link_good,
	input  wire logic        collision,
	input  wire logic        descr_locked,
	input  wire logic        good_polarity,
	input  wire logic        disconnect_detect,
	input  wire logic [4:0]  indicator_in,
	output logic [4:0]       indicator_out,
	output logic [4:0]       indicator_oe_n,
	output logic             serial_10,
	output logic             coder_bypass,
	output logic             align_bypass,
	output logic             scr_bypass,
	output logic             mii_isolate,
	output logic             an_enable,
	output logic [4:0]       adv_abilities,
	output logic             speed100,
	output logic             full_duplex,
	output logic             loopback_100,
	output logic             loopback_10,
	output logic             low_power,
	output logic             power_down,
	output logic             soft_power_down
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic is_mid(input logic [1:0] code);
		return code[1]; // [R3]
	endfunction : is_mid

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
			input logic [15:0] mask);
		return (old & ~mask) | (wd[15:0] & mask);
	endfunction : merge

	// ----------------------------------------
	// state
	// ----------------------------------------
	localparam int STRETCH_W_L = phsc_pkg::STRETCH_W;
	localparam logic [STRETCH_W_L-1:0] STR_LOAD = STRETCH_W_L'(STRETCH_CYCLES);
	logic [15:0] ctrl, next_ctrl;
	logic [15:0] adv, next_adv;
	logic [15:0] cfg, next_cfg;
	logic [15:0] byp, next_byp;
	logic [15:0] stat10, next_stat10;
	logic        f_sp100, next_f_sp100;
	logic        f_full, next_f_full;
	logic        lps, next_lps;
	logic        mdc_q, next_mdc_q;
	logic        wr_pend, next_wr_pend;
	logic [5:0]  wr_idx, next_wr_idx;
	logic [31:0] next_hrdata;
	logic [STRETCH_W_L-1:0] cnt [3];
	logic [STRETCH_W_L-1:0] next_cnt [3];
	logic [2:0]  evt;
	logic [2:0]  lit;
	logic [4:0]  next_oe_n;
	logic        sp100_eff, full_eff;
	logic        an_sp, an_fd, an_one_mid, an_both_mid;
	logic        next_an_en;
	logic [15:0] next_adv_strap;

	// ----------------------------------------
	// strap decode
	// ----------------------------------------
	always_comb begin
		an_both_mid = is_mid(negotiation_strap_pair_1) & is_mid(negotiation_strap_pair_0);
		an_one_mid  = is_mid(negotiation_strap_pair_1) ^ is_mid(negotiation_strap_pair_0);
		an_sp = 1'b0;
		an_fd = 1'b0;
		if (is_mid(negotiation_strap_pair_0)) begin
			an_sp = 1'b0; // [R4]
			an_fd = negotiation_strap_pair_1[0];
		end else if (is_mid(negotiation_strap_pair_1)) begin
			an_sp = 1'b1; // [R4]
			an_fd = negotiation_strap_pair_0[0];
		end else begin
			an_sp = negotiation_strap_pair_1[0]; // [R5]
			an_fd = negotiation_strap_pair_0[0];
		end
		next_an_en = ~an_one_mid; // [R4] [R5]
		next_adv_strap = 16'h0000;
		if (an_both_mid) begin
			next_adv_strap[phsc_pkg::ADV_10H]  = 1'b1; // [R5]
			next_adv_strap[phsc_pkg::ADV_10F]  = 1'b1;
			next_adv_strap[phsc_pkg::ADV_100H] = 1'b1;
			next_adv_strap[phsc_pkg::ADV_100F] = 1'b1;
		end else if (!an_one_mid) begin
			next_adv_strap[phsc_pkg::ADV_10H]  = ~an_sp & ~an_fd; // [R5]
			next_adv_strap[phsc_pkg::ADV_10F]  = ~an_sp & an_fd;
			next_adv_strap[phsc_pkg::ADV_100H] = an_sp & ~an_fd;
			next_adv_strap[phsc_pkg::ADV_100F] = an_sp & an_fd;
		end
	end

	// ----------------------------------------
	// effective speed and duplex
	// ----------------------------------------
	always_comb begin
		sp100_eff = ctrl[phsc_pkg::CTRL_AN_EN] ? an_speed100 : f_sp100;
		full_eff  = ctrl[phsc_pkg::CTRL_AN_EN] ? an_full : f_full;
	end

	// ----------------------------------------
	// pulse stretchers
	// ----------------------------------------
	assign evt = {collision, rx_active, tx_active};
	generate
		for (genvar g = 0; g < 3; g++) begin : g_str
			always_comb begin
				if (evt[g]) begin
					next_cnt[g] = STR_LOAD; // [R24]
				end else if (cnt[g] != '0) begin
					next_cnt[g] = cnt[g] - STRETCH_W_L'(1);
				end else begin
					next_cnt[g] = cnt[g];
				end
				lit[g] = evt[g] | (cnt[g] != '0);
			end
			always_ff @(posedge mclk) begin
				if (rst) begin
					cnt[g] <= '0;
				end else begin
					cnt[g] <= next_cnt[g];
				end
			end
		end
	endgenerate

	always_comb begin
		next_oe_n = 5'h1F;
		next_oe_n[phsc_pkg::IND_TX] = cfg[phsc_pkg::CFG_DISC_SEL] ? ~disconnect_detect
			: ~lit[0]; // [R15]
		next_oe_n[phsc_pkg::IND_RX] = ~lit[1]; // [R16]
		next_oe_n[phsc_pkg::IND_LINK] = ~link_good; // [R16]
		if (sp100_eff) begin
			next_oe_n[phsc_pkg::IND_DPX] = ~full_eff; // [R17]
		end else begin
			next_oe_n[phsc_pkg::IND_DPX] = cfg[phsc_pkg::CFG_POL_SEL] ? ~full_eff
				: ~good_polarity; // [R17]
		end
		next_oe_n[phsc_pkg::IND_COL] = cfg[phsc_pkg::CFG_LOCK_SEL]
			? ~(descr_locked & sp100_eff) : ~lit[2]; // [R18]
	end

	// ----------------------------------------
	// bus slave and register next values
	// ----------------------------------------
	always_comb begin
		next_ctrl    = ctrl;
		next_adv     = adv;
		next_cfg     = cfg;
		next_byp     = byp;
		next_stat10  = stat10;
		next_f_sp100 = f_sp100;
		next_f_full  = f_full;
		next_mdc_q   = mdc;
		next_lps     = lps;
		next_wr_pend = 1'b0;
		next_wr_idx  = wr_idx;
		next_hrdata  = hrdata;
		if (rst) begin
			next_ctrl = 16'h0000;
			next_ctrl[phsc_pkg::CTRL_AN_EN]   = next_an_en; // [R23]
			next_ctrl[phsc_pkg::CTRL_ISOLATE] = isolate_default_strap; // [R14]
			next_adv    = next_adv_strap;
			next_cfg    = phsc_pkg::CFG_RESET;
			next_byp    = 16'h0000;
			next_byp[phsc_pkg::BYP_CODER] = coder_bypass_strap; // [R8]
			next_byp[phsc_pkg::BYP_ALIGN] = alignment_bypass_strap; // [R10]
			next_byp[phsc_pkg::BYP_SCR]   = scrambler_bypass_strap; // [R12]
			next_stat10 = 16'h0000;
			next_stat10[phsc_pkg::STAT10_SER] = serial_mode_strap; // [R2]
			next_f_sp100 = an_sp;
			next_f_full  = an_fd;
			next_lps     = ~low_power_start_strap_n; // [R20]
			next_hrdata  = 32'h0000_0000;
		end else begin
			if (mdc != mdc_q) begin
				next_lps = 1'b0; // [R20]
			end
			if (wr_pend) begin
				unique case (wr_idx)
					phsc_pkg::IDX_CTRL:
						next_ctrl = merge(ctrl, hwdata, phsc_pkg::CTRL_WMASK); // [R6] [R14] [R22]
					phsc_pkg::IDX_ADV:
						next_adv = merge(adv, hwdata, phsc_pkg::ADV_WMASK); // [R6]
					phsc_pkg::IDX_CFG:
						next_cfg = merge(cfg, hwdata, phsc_pkg::CFG_WMASK);
					phsc_pkg::IDX_BYP:
						next_byp = merge(byp, hwdata, phsc_pkg::BYP_WMASK); // [R8] [R10] [R12]
					phsc_pkg::IDX_STAT10:
						next_stat10 = merge(stat10, hwdata, phsc_pkg::STAT10_WMASK); // [R2]
					default: ;
				endcase
			end
			if (hsel && htrans[1] && hready) begin
				next_wr_pend = hwrite;
				next_wr_idx  = haddr[7:2];
				unique case (haddr[7:2])
					phsc_pkg::IDX_CTRL:   next_hrdata = {16'h0000, ctrl};
					phsc_pkg::IDX_ADV:    next_hrdata = {16'h0000, adv};
					phsc_pkg::IDX_CFG:    next_hrdata = {16'h0000, cfg};
					phsc_pkg::IDX_BYP:    next_hrdata = {16'h0000, byp};
					phsc_pkg::IDX_STAT10: next_hrdata = {16'h0000, stat10};
					phsc_pkg::IDX_MODE:   next_hrdata = {24'h000000, power_down_pin, lps,
						loopback_pin, f_full, f_sp100, full_eff, sp100_eff, serial_10};
					default:              next_hrdata = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		ctrl      <= next_ctrl;
		adv       <= next_adv;
		cfg       <= next_cfg;
		byp       <= next_byp;
		stat10    <= next_stat10;
		f_sp100   <= next_f_sp100;
		f_full    <= next_f_full;
		lps       <= next_lps;
		mdc_q     <= next_mdc_q;
		wr_pend   <= next_wr_pend;
		wr_idx    <= next_wr_idx;
		hrdata    <= next_hrdata;
	end

	// ----------------------------------------
	// mode outputs
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			hreadyout       <= 1'b1;
			hresp           <= 1'b0;
			indicator_out   <= 5'h00;
			indicator_oe_n  <= 5'h1F;
			serial_10       <= 1'b0;
			coder_bypass    <= 1'b0;
			align_bypass    <= 1'b0;
			scr_bypass      <= 1'b0;
			mii_isolate     <= 1'b0;
			an_enable       <= 1'b0;
			adv_abilities   <= 5'h00;
			speed100        <= 1'b0;
			full_duplex     <= 1'b0;
			loopback_100    <= 1'b0;
			loopback_10     <= 1'b0;
			low_power       <= 1'b0;
			power_down      <= 1'b0;
			soft_power_down <= 1'b0;
		end else begin
			hreadyout       <= 1'b1;
			hresp           <= 1'b0;
			indicator_out   <= 5'h00;
			indicator_oe_n  <= next_oe_n;
			serial_10       <= stat10[phsc_pkg::STAT10_SER] & ~sp100_eff; // [R1]
			coder_bypass    <= byp[phsc_pkg::BYP_CODER] | byp[phsc_pkg::BYP_ALIGN]; // [R7] [R9]
			align_bypass    <= byp[phsc_pkg::BYP_ALIGN]; // [R9]
			scr_bypass      <= byp[phsc_pkg::BYP_SCR] | byp[phsc_pkg::BYP_ALIGN]; // [R11]
			mii_isolate     <= ctrl[phsc_pkg::CTRL_ISOLATE]; // [R13]
			an_enable       <= ctrl[phsc_pkg::CTRL_AN_EN]; // [R6]
			adv_abilities   <= {adv[10], adv[8:5]}; // [R6]
			speed100        <= sp100_eff;
			full_duplex     <= full_eff;
			loopback_100    <= loopback_pin & sp100_eff; // [R19]
			loopback_10     <= loopback_pin & ~sp100_eff; // [R19]
			low_power       <= lps; // [R20]
			power_down      <= power_down_pin; // [R21]
			soft_power_down <= ctrl[phsc_pkg::CTRL_PDOWN]; // [R22]
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	logic rst_q;
	logic [5:0] strap_q;
	always_ff @(posedge mclk) begin
		rst_q <= rst;
		if (rst) begin
			strap_q <= {serial_mode_strap, isolate_default_strap, coder_bypass_strap,
				scrambler_bypass_strap, alignment_bypass_strap, an_one_mid};
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	AST_SER_LATCH: assert property (rst_q |-> stat10[9] == strap_q[5]) // [R2]
		else $error("serial strap not latched");
	AST_ISO_LATCH: assert property (rst_q |-> ctrl[10] == strap_q[4] // [R13] [R14]
		##1 mii_isolate == strap_q[4])
		else $error("isolate strap not applied");
	AST_BYP_LATCH: assert property (rst_q |-> byp[14:12] == strap_q[3:1]) // [R8] [R10] [R12]
		else $error("bypass straps not latched");
	AST_FORCED: assert property (rst_q && strap_q[0] |-> !ctrl[8] ##1 !an_enable) // [R4]
		else $error("forced mode not taken");
	AST_PDOWN: assert property (power_down_pin |=> power_down) // [R21]
		else $error("power down pin ignored");
	AST_LPS_END: assert property (lps && (mdc != mdc_q) |=> !lps ##1 !low_power) // [R20]
		else $error("low power not left on mdc toggle");
	AST_SERIAL: assert property (stat10[9] && !sp100_eff |=> serial_10) // [R1]
		else $error("serial mode not active");
	AST_LOOP: assert property (loopback_pin && sp100_eff |=> loopback_100 && !loopback_10) // [R19]
		else $error("loopback path wrong");
	AST_TX_STRETCH: assert property ($fell(tx_active) && !cfg[2] // [R15] [R24]
		|=> !indicator_oe_n[0] [*8])
		else $error("tx indicator not stretched");
	AST_LOCK: assert property (cfg[11] && descr_locked && sp100_eff |=> !indicator_oe_n[4]) // [R18]
		else $error("lock indicator not lit");
	AST_LINK: assert property (link_good |=> !indicator_oe_n[2]) // [R16]
		else $error("link indicator not lit");
	AST_DPX100: assert property (sp100_eff && full_eff |=> !indicator_oe_n[3]) // [R17]
		else $error("duplex indicator not lit");
	COV_WRITE: cover property (hsel && htrans[1] && hwrite ##1 wr_pend);
	COV_AUTO: cover property (rst_q && ctrl[8]);
	COV_COL: cover property ($fell(collision) ##1 !indicator_oe_n[4]);
endmodule : phsc_strap_loader

// file: dv/phsc_board.sv
// board strap resistors, indicator pull-ups and management clock model
`timescale 1ns/10ps
module phsc_board (
	input  wire logic       mclk,
	input  wire logic [5:0] fit,
	input  wire logic [1:0] lvl1,
	input  wire logic [1:0] lvl0,
	input  wire logic       mdc_run,
	input  wire logic [4:0] ind_out,
	input  wire logic [4:0] oe_n,
	output logic      [5:0] pins,
	output logic      [1:0] an1,
	output logic      [1:0] an0,
	output logic            mdc,
	output logic      [4:0] led
);
	// ----------------------------------------
	// straps: fitted resistor drives the pin
	// ----------------------------------------
	assign pins = {~fit[5], fit[4:0]};
	// level 2 is an open pin, pulled to mid
	assign an1 = (lvl1 == 2'h2) ? 2'h3 : {1'b0, lvl1[0]};
	assign an0 = (lvl0 == 2'h2) ? 2'h3 : {1'b0, lvl0[0]};
	// ----------------------------------------
	// pull-up on released indicators, mdc idle low
	// ----------------------------------------
	assign led = ind_out | oe_n;
	always_ff @(posedge mclk) begin
		mdc <= mdc_run ? ~mdc : 1'b0;
	end
endmodule : phsc_board

// file: dv/tb_top.sv
// scenario testbench for the strap loader and indicators
`timescale 1ns/10ps
module tb_top;
	logic        mclk = 1'b0;
	logic        rst, hsel, hwrite, hreadyout, hresp, mdc_run, mdc;
	logic [7:0]  haddr;
	logic [1:0]  htrans, lvl1, lvl0, an1, an0;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, rd;
	logic [5:0]  fit, pins;
	logic [4:0]  led, ind_out, oe_n, adv_abilities;
	logic        an_speed100, an_full, tx_active, rx_active, link_good, collision;
	logic        descr_locked, good_polarity, disconnect_detect, loopback_pin, power_down_pin;
	logic        serial_10, coder_bypass, align_bypass, scr_bypass, mii_isolate, an_enable;
	logic        speed100, full_duplex, loopback_100, loopback_10, low_power, power_down;
	logic        soft_power_down;
	int          mismatches = 0;
	int          compares = 0;
	int          cycles = 0;
	// ----------------------------------------
	// instances
	// ----------------------------------------
	phsc_strap_loader #(.STRETCH_CYCLES(16)) u_phsc_strap_loader (.mclk(mclk), .rst(rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .serial_mode_strap(pins[0]), .negotiation_strap_pair_1(an1),
		.negotiation_strap_pair_0(an0), .coder_bypass_strap(pins[1]),
		.alignment_bypass_strap(pins[2]), .scrambler_bypass_strap(pins[3]),
		.isolate_default_strap(pins[4]), .low_power_start_strap_n(pins[5]),
		.loopback_pin(loopback_pin), .power_down_pin(power_down_pin), .mdc(mdc),
		.an_speed100(an_speed100), .an_full(an_full), .tx_active(tx_active),
		.rx_active(rx_active), .link_good(link_good), .collision(collision),
		.descr_locked(descr_locked), .good_polarity(good_polarity),
		.disconnect_detect(disconnect_detect), .indicator_in(led), .indicator_out(ind_out),
		.indicator_oe_n(oe_n), .serial_10(serial_10), .coder_bypass(coder_bypass),
		.align_bypass(align_bypass), .scr_bypass(scr_bypass), .mii_isolate(mii_isolate),
		.an_enable(an_enable), .adv_abilities(adv_abilities), .speed100(speed100),
		.full_duplex(full_duplex), .loopback_100(loopback_100), .loopback_10(loopback_10),
		.low_power(low_power), .power_down(power_down), .soft_power_down(soft_power_down));
	phsc_board u_phsc_board (.mclk(mclk), .fit(fit), .lvl1(lvl1), .lvl0(lvl0),
		.mdc_run(mdc_run), .ind_out(ind_out), .oe_n(oe_n), .pins(pins), .an1(an1),
		.an0(an0), .mdc(mdc), .led(led));
	// ----------------------------------------
	// clock, timeout, shared tasks
	// ----------------------------------------
	always #50 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc
	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic do_reset(input int n);
		@(posedge mclk);
		rst <= 1'b1;
		repeat (n) @(posedge mclk);
		rst <= 1'b0;
		cyc(3);
	endtask : do_reset
	task automatic see(input int i, input logic e);
		cyc(20);
		check({31'h0, led[i]}, {31'h0, e});
		@(posedge mclk);
	endtask : see
	task automatic pulse(input int k);
		@(posedge mclk);
		{collision, rx_active, tx_active} <= 3'h1 << k;
		@(posedge mclk);
		{collision, rx_active, tx_active} <= 3'h0;
	endtask : pulse
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic s_straps;
		bus(8'h6C, 1'b0, 32'h0);
		check(rd, 32'h0000_0200);
		check({30'h0, hreadyout, hresp}, 32'h2);
		bus(8'h60, 1'b0, 32'h0);
		check(rd, 32'h0000_7000);
		bus(8'h00, 1'b0, 32'h0);
		check(rd, 32'h0000_0500);
		cyc(1);
		check({26'h0, serial_10, coder_bypass, align_bypass, scr_bypass, mii_isolate,
			low_power}, 32'h3E);
		@(posedge mclk);
		an_speed100 <= 1'b1;
		cyc(3);
		check({31'h0, serial_10}, 32'h0);
		@(posedge mclk);
		fit <= 6'h00;
		do_reset(2);
		bus(8'h60, 1'b0, 32'h0);
		check(rd, 32'h0);
		cyc(1);
		check({27'h0, coder_bypass, align_bypass, scr_bypass, mii_isolate, serial_10},
			32'h0);
	endtask : s_straps
	task automatic s_neg;
		int l1[9] = '{0, 1, 2, 2, 2, 0, 0, 1, 1};
		int l0[9] = '{2, 2, 0, 1, 2, 0, 1, 0, 1};
		foreach (l1[i]) begin
			@(posedge mclk);
			lvl1 <= 2'(l1[i]);
			lvl0 <= 2'(l0[i]);
			do_reset(2);
			check({31'h0, an_enable}, 32'(i > 3));
			if (i < 4)
				check({30'h0, speed100, full_duplex}, 32'(i));
			else
				check({28'h0, adv_abilities[3:0]}, (i == 4) ? 32'hF : 32'h1 << (i - 5));
			if (i == 2) begin
				bus(8'h80, 1'b0, 32'h0);
				check(rd, 32'h0000_000A);
			end
		end
		@(posedge mclk);
		lvl1 <= 2'h2;
		lvl0 <= 2'h2;
		do_reset(2);
	endtask : s_neg
	task automatic s_led;
		int sl[3] = '{0, 1, 4};
		foreach (sl[j]) begin
			pulse(j);
			cyc(1);
			check({31'h0, led[sl[j]]}, 32'h0);
			cyc(11);
			pulse(j);
			cyc(12);
			check({31'h0, led[sl[j]]}, 32'h0);
			cyc(8);
			check({31'h0, led[sl[j]]}, 32'h1);
		end
		@(posedge mclk);
		an_full <= 1'b1;
		see(3, 1'b0);
		an_full <= 1'b0;
		see(3, 1'b1);
		link_good <= 1'b1;
		see(2, 1'b0);
		link_good <= 1'b0;
		see(2, 1'b1);
		bus(8'h5C, 1'b1, 32'h0000_0004);
		disconnect_detect <= 1'b1;
		see(0, 1'b0);
		disconnect_detect <= 1'b0;
		see(0, 1'b1);
		bus(8'h5C, 1'b1, 32'h0000_0800);
		descr_locked <= 1'b1;
		see(4, 1'b0);
		descr_locked <= 1'b0;
		see(4, 1'b1);
		bus(8'h5C, 1'b1, 32'h0);
		an_speed100 <= 1'b0;
		good_polarity <= 1'b1;
		see(3, 1'b0);
		good_polarity <= 1'b0;
		see(3, 1'b1);
		bus(8'h5C, 1'b1, 32'h0000_0002);
		an_full <= 1'b1;
		see(3, 1'b0);
	endtask : s_led
	task automatic s_pwr;
		an_speed100 <= 1'b1;
		loopback_pin <= 1'b1;
		power_down_pin <= 1'b1;
		cyc(3);
		check({29'h0, loopback_100, loopback_10, power_down}, 32'h5);
		@(posedge mclk);
		an_speed100 <= 1'b0;
		power_down_pin <= 1'b0;
		cyc(3);
		check({29'h0, loopback_100, loopback_10, power_down}, 32'h2);
		@(posedge mclk);
		loopback_pin <= 1'b0;
		fit <= 6'h20;
		do_reset(2);
		cyc(10);
		check({31'h0, low_power}, 32'h1);
		@(posedge mclk);
		mdc_run <= 1'b1;
		cyc(4);
		check({31'h0, low_power}, 32'h0);
		@(posedge mclk);
		mdc_run <= 1'b0;
		do_reset(2);
		check({31'h0, low_power}, 32'h1);
		@(posedge mclk);
		fit <= 6'h00;
		do_reset(2);
		check({31'h0, low_power}, 32'h0);
	endtask : s_pwr
	task automatic s_sw;
		bus(8'h60, 1'b1, 32'hFFFF_FFFF);
		bus(8'h60, 1'b0, 32'h0);
		check(rd, 32'h0000_7000);
		bus(8'h60, 1'b1, 32'h0000_4000);
		cyc(3);
		check({29'h0, coder_bypass, align_bypass, scr_bypass}, 32'h4);
		bus(8'h60, 1'b1, 32'h0000_2000);
		cyc(3);
		check({29'h0, coder_bypass, align_bypass, scr_bypass}, 32'h1);
		bus(8'h60, 1'b1, 32'h0000_1000);
		cyc(3);
		check({29'h0, coder_bypass, align_bypass, scr_bypass}, 32'h7);
		bus(8'h6C, 1'b1, 32'h0000_0200);
		cyc(3);
		check({31'h0, serial_10}, 32'h1);
		bus(8'h00, 1'b1, 32'h0000_0C00);
		cyc(3);
		check({29'h0, an_enable, mii_isolate, soft_power_down}, 32'h3);
		bus(8'h10, 1'b1, 32'h0000_0420);
		cyc(3);
		check({27'h0, adv_abilities}, 32'h11);
		bus(8'h40, 1'b1, 32'hFFFF_FFFF);
		bus(8'h40, 1'b0, 32'h0);
		check(rd, 32'h0);
	endtask : s_sw
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		{hsel, hwrite, mdc_run, an_speed100, an_full, tx_active, rx_active} = '0;
		{link_good, collision, descr_locked, good_polarity, disconnect_detect} = '0;
		{loopback_pin, power_down_pin, haddr, htrans, hwdata} = '0;
		hsize = 3'h2;
		fit = 6'h1F;
		lvl1 = 2'h2;
		lvl0 = 2'h2;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		cyc(3);
		s_straps();
		s_neg();
		s_led();
		s_pwr();
		s_sw();
		give_verdict();
	end
endmodule : tb_top
